/* core/fsr_pkg.sv */
// fsr_pkg: register indices, field positions, write masks and reset values
// for the fail-safe read-back register bank.
// assumes data bit n of the 16-bit register port carries register bit n+8.
package fsr_pkg;

    // ****************************************************************
    // register indices on the control port
    // ****************************************************************
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 16;
    localparam logic [3:0]  IDX_GROUP       = 4'h0;
    localparam logic [3:0]  IDX_REACT_CORE  = 4'h1;
    localparam logic [3:0]  IDX_REACT_AUX   = 4'h2;
    localparam logic [3:0]  IDX_SUPERVISION = 4'h3;
    localparam logic [3:0]  IDX_CORE_OFFSET = 4'h4;
    localparam logic [3:0]  IDX_MON_STATUS  = 4'h5;
    localparam logic [3:0]  IDX_PIN_STATUS  = 4'h6;
    localparam logic [3:0]  IDX_DIAG        = 4'h7;
    localparam logic [3:0]  IDX_INH_MASK    = 4'h8;
    localparam logic [3:0]  IDX_STATE       = 4'h9;

    // ****************************************************************
    // field positions (data bit = register bit - 8)
    // ****************************************************************
    localparam int POS_COMM_G      = 15;
    localparam int POS_PIN_G       = 13;
    localparam int POS_MON_G       = 12;
    // monitor status: six monitor flags and two internal faults
    localparam int POS_CORE_OV     = 15;
    localparam int POS_CORE_UV     = 14;
    localparam int POS_IO_OV       = 13;
    localparam int POS_IO_UV       = 12;
    localparam int POS_AUX_OV      = 5;
    localparam int POS_AUX_UV      = 4;
    localparam int POS_REF_OV      = 2;
    localparam int POS_OSC_DRIFT   = 1;
    // pin status
    localparam int POS_PG_DIAG     = 15;
    localparam int POS_PG_EVENT    = 14;
    localparam int POS_PG_SENSE    = 13;
    localparam int POS_EXT_RST     = 12;
    localparam int POS_RST_DRIVE   = 11;
    localparam int POS_RST_SENSE   = 10;
    localparam int POS_RST_EVENT   = 9;
    localparam int POS_RST_DIAG    = 8;
    localparam int POS_RST_REQ     = 7;
    // diagnostics
    localparam int POS_ERR_MON     = 11;
    localparam int POS_BUS_CRC     = 2;
    localparam int POS_BUS_REQ     = 1;
    // supervision
    localparam int POS_CNT_LSB     = 0;
    localparam int CNT_W           = 4;
    // state report
    localparam int POS_DBG_MODE    = 13;
    localparam int POS_OTP_BAD     = 11;
    localparam int POS_REG_BAD     = 9;
    localparam int STATE_W         = 5;

    // ****************************************************************
    // storage masks and reset values
    // ****************************************************************
    localparam logic [15:0] WMASK_REACT_CORE = 16'hF00F;
    localparam logic [15:0] WMASK_REACT_AUX  = 16'h000F;
    localparam logic [15:0] WMASK_SUPERV     = 16'hC210;
    localparam logic [15:0] WMASK_OFFSET     = 16'hF800;
    localparam logic [15:0] WMASK_INH        = 16'h0070;
    localparam logic [15:0] W1C_MON          = 16'hF036;
    localparam logic [15:0] W1C_PIN          = 16'hD300;
    localparam logic [15:0] W1C_DIAG         = 16'h0006;
    localparam logic [15:0] RST_REACT_CORE   = 16'hD00D;
    localparam logic [15:0] RST_REACT_AUX    = 16'h000D;
    localparam logic [15:0] RST_SUPERV       = 16'h4000;
    localparam logic [15:0] RST_OFFSET       = 16'h0000;
    localparam logic [15:0] RST_INH          = 16'h0000;
    // core undervoltage stands flagged at power-on, so the monitor summary reads 1
    localparam logic [15:0] RST_MON          = 16'h4000;
    localparam logic [15:0] RST_PIN          = 16'h0000;
    localparam logic [15:0] RST_DIAG         = 16'h0000;

endpackage : fsr_pkg

/* core/fsr_flags_if.sv */
// fsr_flags_if: carries the held flag registers to the summary logic and
// the three summary bits back.
// assumes one clock domain; pure wires.
`timescale 1ns/10ps
interface fsr_flags_if;
    logic [15:0] mon_flags;
    logic [15:0] pin_flags;
    logic [15:0] diag_flags;
    logic        comm_group_flag;
    logic        pin_group_flag;
    logic        monitor_group_flag;

    modport source  (output mon_flags, pin_flags, diag_flags,
                     input  comm_group_flag, pin_group_flag, monitor_group_flag);
    modport summary (input  mon_flags, pin_flags, diag_flags,
                     output comm_group_flag, pin_group_flag, monitor_group_flag);
endinterface : fsr_flags_if

/* core/fsr_pin_sync.sv */
// fsr_pin_sync: two-stage synchroniser for pin-level inputs.
// assumes inputs are levels; the first stage feeds only the second.
`timescale 1ns/10ps
module fsr_pin_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : fsr_pin_sync

/* core/fsr_group_flags.sv */
// fsr_group_flags: OR summaries of the held fail-safe flags.
// assumes flag vectors are register outputs on the same clock.
`timescale 1ns/10ps
module fsr_group_flags
    import fsr_pkg::*;
(
    fsr_flags_if.summary flags
);
    // purely combinational so each summary drops the moment its last source clears
    assign flags.comm_group_flag    = flags.diag_flags[POS_BUS_CRC]
                                    | flags.diag_flags[POS_BUS_REQ];
    assign flags.pin_group_flag     = flags.pin_flags[POS_PG_DIAG]
                                    | flags.pin_flags[POS_RST_DIAG];
    assign flags.monitor_group_flag = flags.mon_flags[POS_CORE_OV]
                                    | flags.mon_flags[POS_CORE_UV]
                                    | flags.mon_flags[POS_IO_OV]
                                    | flags.mon_flags[POS_IO_UV]
                                    | flags.mon_flags[POS_AUX_OV]
                                    | flags.mon_flags[POS_AUX_UV];
endmodule : fsr_group_flags

/* core/fsr_readback.sv */
// fsr_readback: fail-safe register bank as seen from the control port.
// assumes the serial front end delivers decoded single-cycle read and
// write strobes on clk; fault sources are pulses from same-clock logic.
`timescale 1ns/10ps

module fsr_readback
    import fsr_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                arst_n,
    // control port
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [DATA_W-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DATA_W-1:0]   reg_rdata,
    output logic                     reg_ack,
    // fault events, one-cycle pulses
    input  wire logic                core_monitor_overvoltage,
    input  wire logic                core_monitor_undervoltage,
    input  wire logic                io_supply_overvoltage,
    input  wire logic                io_supply_undervoltage,
    input  wire logic                aux_monitor_overvoltage,
    input  wire logic                aux_monitor_undervoltage,
    input  wire logic                ref_overvoltage_evt,
    input  wire logic                osc_drift_evt,
    input  wire logic                power_good_diag_fault,
    input  wire logic                power_good_evt,
    input  wire logic                ext_reset_evt,
    input  wire logic                reset_pin_evt,
    input  wire logic                reset_pin_diag_fault,
    input  wire logic                bus_crc_error,
    input  wire logic                bus_request_error,
    // live status from the safety state machine
    input  wire logic                error_monitor_live,
    input  wire logic                reset_drive_live,
    input  wire logic                debug_mode_live,
    input  wire logic                otp_corrupt_live,
    input  wire logic                reg_corrupt_live,
    input  wire logic [CNT_W-1:0]    fault_error_counter,
    input  wire logic [STATE_W-1:0]  safety_state_code,
    // pins sensed back
    input  wire logic                power_good_pin,
    input  wire logic                reset_pin,
    // configuration, reset request and group summaries out
    output logic      [DATA_W-1:0]   core_io_reaction,
    output logic      [DATA_W-1:0]   aux_reaction,
    output logic      [DATA_W-1:0]   supervision_cfg,
    output logic      [DATA_W-1:0]   core_offset_cfg,
    output logic      [DATA_W-1:0]   inhibit_mask,
    output logic                     reset_request,
    output logic                     comm_group_flag,
    output logic                     pin_group_flag,
    output logic                     monitor_group_flag
);

    // ****************************************************************
    // decode
    // ****************************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
        hit = (a == idx);
    endfunction : hit

    wire logic wr_react_core = reg_wr && hit(reg_addr, IDX_REACT_CORE);
    wire logic wr_react_aux  = reg_wr && hit(reg_addr, IDX_REACT_AUX);
    wire logic wr_superv     = reg_wr && hit(reg_addr, IDX_SUPERVISION);
    wire logic wr_offset     = reg_wr && hit(reg_addr, IDX_CORE_OFFSET);
    wire logic wr_mon        = reg_wr && hit(reg_addr, IDX_MON_STATUS);
    wire logic wr_pin        = reg_wr && hit(reg_addr, IDX_PIN_STATUS);
    wire logic wr_diag       = reg_wr && hit(reg_addr, IDX_DIAG);
    wire logic wr_inh        = reg_wr && hit(reg_addr, IDX_INH_MASK);

    // ****************************************************************
    // pin sense synchronisers
    // ****************************************************************
    logic [1:0] pin_sense;

    fsr_pin_sync #(.W(2)) u_pin_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in ({power_good_pin, reset_pin}),
        .sync_out (pin_sense)
    );

    // ****************************************************************
    // flag sources and clears
    // ****************************************************************
    logic [DATA_W-1:0] mon_set;
    logic [DATA_W-1:0] pin_set;
    logic [DATA_W-1:0] diag_set;

    always_comb begin
        mon_set                 = '0;
        mon_set[POS_CORE_OV]    = core_monitor_overvoltage;
        mon_set[POS_CORE_UV]    = core_monitor_undervoltage;
        mon_set[POS_IO_OV]      = io_supply_overvoltage;
        mon_set[POS_IO_UV]      = io_supply_undervoltage;
        mon_set[POS_AUX_OV]     = aux_monitor_overvoltage;
        mon_set[POS_AUX_UV]     = aux_monitor_undervoltage;
        mon_set[POS_REF_OV]     = ref_overvoltage_evt;
        mon_set[POS_OSC_DRIFT]  = osc_drift_evt;
        pin_set                 = '0;
        pin_set[POS_PG_DIAG]    = power_good_diag_fault;
        pin_set[POS_PG_EVENT]   = power_good_evt;
        pin_set[POS_EXT_RST]    = ext_reset_evt;
        pin_set[POS_RST_EVENT]  = reset_pin_evt;
        pin_set[POS_RST_DIAG]   = reset_pin_diag_fault;
        diag_set                = '0;
        diag_set[POS_BUS_CRC]   = bus_crc_error;
        diag_set[POS_BUS_REQ]   = bus_request_error;
    end

    // write-one-to-clear; a fresh event in the clearing cycle wins
    wire logic [DATA_W-1:0] mon_clr  = wr_mon  ? (reg_wdata & W1C_MON)  : '0;
    wire logic [DATA_W-1:0] pin_clr  = wr_pin  ? (reg_wdata & W1C_PIN)  : '0;
    wire logic [DATA_W-1:0] diag_clr = wr_diag ? (reg_wdata & W1C_DIAG) : '0;

    // ****************************************************************
    // held registers
    // ****************************************************************
    logic [DATA_W-1:0] react_core_reg;
    logic [DATA_W-1:0] react_aux_reg;
    logic [DATA_W-1:0] superv_reg;
    logic [DATA_W-1:0] offset_reg;
    logic [DATA_W-1:0] inh_reg;
    logic [DATA_W-1:0] mon_reg;
    logic [DATA_W-1:0] pin_reg;
    logic [DATA_W-1:0] diag_reg;
    logic              rst_req_reg;

    wire logic [DATA_W-1:0] mon_next  = ((mon_reg  & ~mon_clr)  | mon_set)  & W1C_MON;
    wire logic [DATA_W-1:0] pin_next  = ((pin_reg  & ~pin_clr)  | pin_set)  & W1C_PIN;
    wire logic [DATA_W-1:0] diag_next = ((diag_reg & ~diag_clr) | diag_set) & W1C_DIAG;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            react_core_reg <= RST_REACT_CORE;
            react_aux_reg  <= RST_REACT_AUX;
            superv_reg     <= RST_SUPERV;
            offset_reg     <= RST_OFFSET;
            inh_reg        <= RST_INH;
            mon_reg        <= RST_MON;
            pin_reg        <= RST_PIN;
            diag_reg       <= RST_DIAG;
            rst_req_reg    <= 1'b0;
        end else begin
            // only defined field bits are stored; the rest stay zero
            if (wr_react_core) react_core_reg <= reg_wdata & WMASK_REACT_CORE;
            if (wr_react_aux)  react_aux_reg  <= reg_wdata & WMASK_REACT_AUX;
            if (wr_superv)     superv_reg     <= reg_wdata & WMASK_SUPERV;
            if (wr_offset)     offset_reg     <= reg_wdata & WMASK_OFFSET;
            if (wr_inh)        inh_reg        <= reg_wdata & WMASK_INH;
            mon_reg     <= mon_next;
            pin_reg     <= pin_next;
            diag_reg    <= diag_next;
            rst_req_reg <= wr_pin && reg_wdata[POS_RST_REQ];
        end
    end

    // ****************************************************************
    // group summaries
    // ****************************************************************
    fsr_flags_if flags ();

    assign flags.mon_flags  = mon_reg;
    assign flags.pin_flags  = pin_reg;
    assign flags.diag_flags = diag_reg;

    fsr_group_flags u_group (
        .flags (flags)
    );

    // ****************************************************************
    // read view
    // ****************************************************************
    logic [DATA_W-1:0] group_view;
    logic [DATA_W-1:0] superv_view;
    logic [DATA_W-1:0] pin_view;
    logic [DATA_W-1:0] diag_view;
    logic [DATA_W-1:0] state_view;

    always_comb begin
        group_view                  = '0;
        group_view[POS_COMM_G]      = flags.comm_group_flag;
        group_view[POS_PIN_G]       = flags.pin_group_flag;
        group_view[POS_MON_G]       = flags.monitor_group_flag;
        superv_view                 = superv_reg;
        superv_view[POS_CNT_LSB +: CNT_W] = fault_error_counter;
        pin_view                    = pin_reg;
        pin_view[POS_PG_SENSE]      = pin_sense[1];
        pin_view[POS_RST_DRIVE]     = reset_drive_live;
        pin_view[POS_RST_SENSE]     = pin_sense[0];
        diag_view                   = diag_reg;
        diag_view[POS_ERR_MON]      = error_monitor_live;
        state_view                  = '0;
        state_view[POS_DBG_MODE]    = debug_mode_live;
        state_view[POS_OTP_BAD]     = otp_corrupt_live;
        state_view[POS_REG_BAD]     = reg_corrupt_live;
        state_view[STATE_W-1:0]     = safety_state_code;
    end

    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        case (reg_addr)
            IDX_GROUP:       rd_mux = group_view;
            IDX_REACT_CORE:  rd_mux = react_core_reg;
            IDX_REACT_AUX:   rd_mux = react_aux_reg;
            IDX_SUPERVISION: rd_mux = superv_view;
            IDX_CORE_OFFSET: rd_mux = offset_reg;
            IDX_MON_STATUS:  rd_mux = mon_reg;
            IDX_PIN_STATUS:  rd_mux = pin_view;
            IDX_DIAG:        rd_mux = diag_view;
            IDX_INH_MASK:    rd_mux = inh_reg;
            IDX_STATE:       rd_mux = state_view;
            default:         rd_mux = '0;
        endcase
    end

    // read data captured one edge after the strobe; writes answer likewise
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= '0;
            reg_ack   <= 1'b0;
        end else begin
            if (reg_rd) reg_rdata <= rd_mux;
            reg_ack <= reg_rd | reg_wr;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign core_io_reaction   = react_core_reg;
    assign aux_reaction       = react_aux_reg;
    assign supervision_cfg    = superv_reg;
    assign core_offset_cfg    = offset_reg;
    assign inhibit_mask       = inh_reg;
    assign reset_request      = rst_req_reg;
    assign comm_group_flag    = flags.comm_group_flag;
    assign pin_group_flag     = flags.pin_group_flag;
    assign monitor_group_flag = flags.monitor_group_flag;

endmodule : fsr_readback

/* tb/fsr_readback_asserts.sv */
// fsr_readback_asserts: port-level checks of the fail-safe read-back bank.
// assumes it is bound to fsr_readback; one clock, async active-low reset.
`timescale 1ns/10ps
module fsr_readback_asserts
    import fsr_pkg::*;
(
    input wire logic                clk,
    input wire logic                arst_n,
    input wire logic [ADDR_W-1:0]   reg_addr,
    input wire logic [DATA_W-1:0]   reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [DATA_W-1:0]   reg_rdata,
    input wire logic                core_monitor_overvoltage,
    input wire logic                core_monitor_undervoltage,
    input wire logic                io_supply_overvoltage,
    input wire logic                io_supply_undervoltage,
    input wire logic                aux_monitor_overvoltage,
    input wire logic                aux_monitor_undervoltage,
    input wire logic                power_good_diag_fault,
    input wire logic                reset_pin_diag_fault,
    input wire logic                bus_crc_error,
    input wire logic                bus_request_error,
    input wire logic [CNT_W-1:0]    fault_error_counter,
    input wire logic [STATE_W-1:0]  safety_state_code,
    input wire logic                comm_group_flag,
    input wire logic                pin_group_flag,
    input wire logic                monitor_group_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ****************************************************************
    // decoded causes
    // ****************************************************************
    wire rd_grp  = reg_rd && (reg_addr == IDX_GROUP);
    wire bus_evt = bus_crc_error || bus_request_error;
    wire mon_any = core_monitor_overvoltage || core_monitor_undervoltage
                || io_supply_overvoltage || io_supply_undervoltage
                || aux_monitor_overvoltage || aux_monitor_undervoltage;

    // ****************************************************************
    // assertions
    // ****************************************************************
    crc_sets_comm_a: assert property (bus_crc_error |=> comm_group_flag)
        else $error("comm summary missed a crc error");
    req_sets_comm_a: assert property (bus_request_error |=> comm_group_flag)
        else $error("comm summary missed a request error");
    pin_diag_sets_a: assert property ((power_good_diag_fault || reset_pin_diag_fault)
        |=> pin_group_flag) else $error("pin summary missed a diag fault");
    monitor_sets_a: assert property (mon_any |=> monitor_group_flag)
        else $error("monitor summary missed a fault");
    group_view_a: assert property (rd_grp |=> reg_rdata == {$past(comm_group_flag),
        1'b0, $past(pin_group_flag), $past(monitor_group_flag), 12'h000})
        else $error("group read differs from summaries");
    comm_self_clear_a: assert property (reg_wr && reg_addr == IDX_DIAG
        && reg_wdata[2:1] == 2'h3 && !bus_evt |=> !comm_group_flag)
        else $error("comm summary stayed set after sources cleared");
    group_ro_a: assert property (reg_wr && reg_addr == IDX_GROUP && !bus_evt
        |=> comm_group_flag == $past(comm_group_flag))
        else $error("group write changed a summary");
    counter_view_a: assert property (reg_rd && reg_addr == IDX_SUPERVISION
        |=> reg_rdata[3:0] == $past(fault_error_counter))
        else $error("fault counter read wrong");
    state_view_a: assert property (reg_rd && reg_addr == IDX_STATE
        |=> reg_rdata[4:0] == $past(safety_state_code)) else $error("state code read wrong");
    group_reserved_a: assert property (rd_grp |=> (reg_rdata & 16'h4FFF) == 16'h0000)
        else $error("group reserved bits nonzero");

    grp_read_c: cover property (rd_grp && comm_group_flag);
    diag_clear_c: cover property (reg_wr && reg_addr == IDX_DIAG);
    pin_rise_c: cover property ($rose(pin_group_flag));
endmodule : fsr_readback_asserts

bind fsr_readback fsr_readback_asserts u_chk (.clk(clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_monitor_overvoltage(core_monitor_overvoltage),
    .core_monitor_undervoltage(core_monitor_undervoltage),
    .io_supply_overvoltage(io_supply_overvoltage),
    .io_supply_undervoltage(io_supply_undervoltage),
    .aux_monitor_overvoltage(aux_monitor_overvoltage),
    .aux_monitor_undervoltage(aux_monitor_undervoltage),
    .power_good_diag_fault(power_good_diag_fault),
    .reset_pin_diag_fault(reset_pin_diag_fault), .bus_crc_error(bus_crc_error),
    .bus_request_error(bus_request_error), .fault_error_counter(fault_error_counter),
    .safety_state_code(safety_state_code), .comm_group_flag(comm_group_flag),
    .pin_group_flag(pin_group_flag), .monitor_group_flag(monitor_group_flag));

/* tb/fsr_readback_bench.sv */
// fsr_readback_bench: self-checking bench for the fail-safe read-back bank.
// assumes the checker file is compiled alongside; pins rise once, late in the run.
`timescale 1ns/10ps
module fsr_readback_bench
    import fsr_pkg::*;
;
    logic                clk = 1'b0;
    logic                arst_n = 1'b0;
    logic [ADDR_W-1:0]   reg_addr = 4'h0;
    logic [DATA_W-1:0]   reg_wdata = 16'h0000;
    logic                reg_wr = 1'b0;
    logic                reg_rd = 1'b0;
    logic [DATA_W-1:0]   reg_rdata;
    logic                reg_ack;
    logic [14:0]         evt = 15'h0000;
    logic [4:0]          live = 5'h00;
    logic [CNT_W-1:0]    cnt = 4'h0;
    logic [STATE_W-1:0]  state = 5'h00;
    logic [1:0]          pins = 2'h0;
    logic [DATA_W-1:0]   aux_cfg;
    logic [DATA_W-1:0]   sup_cfg;
    int                  errors = 0;
    int                  check_count = 0;

    always #2 clk = ~clk;

    fsr_readback dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .core_monitor_overvoltage(evt[0]),
        .core_monitor_undervoltage(evt[1]), .io_supply_overvoltage(evt[2]),
        .io_supply_undervoltage(evt[3]), .aux_monitor_overvoltage(evt[4]),
        .aux_monitor_undervoltage(evt[5]), .ref_overvoltage_evt(evt[6]),
        .osc_drift_evt(evt[7]), .power_good_diag_fault(evt[8]), .power_good_evt(evt[9]),
        .ext_reset_evt(evt[10]), .reset_pin_evt(evt[11]), .reset_pin_diag_fault(evt[12]),
        .bus_crc_error(evt[13]), .bus_request_error(evt[14]),
        .error_monitor_live(live[0]), .reset_drive_live(live[1]), .debug_mode_live(live[2]),
        .otp_corrupt_live(live[3]), .reg_corrupt_live(live[4]), .fault_error_counter(cnt),
        .safety_state_code(state), .power_good_pin(pins[1]), .reset_pin(pins[0]),
        .core_io_reaction(), .aux_reaction(aux_cfg), .supervision_cfg(sup_cfg),
        .core_offset_cfg(),
        .inhibit_mask(), .reset_request(), .comm_group_flag(), .pin_group_flag(),
        .monitor_group_flag());

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic end_of_test();
        $display("errors %0d, checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    // ack is checked with every access so a missing answer is never silent
    task automatic access(input logic wr, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        check("ack", {15'h0000, reg_ack}, 16'h0001);
    endtask : access

    task automatic rdc(input string name, input logic [3:0] a, input logic [15:0] exp);
        access(1'b0, a, 16'h0000);
        check(name, reg_rdata, exp);
    endtask : rdc

    task automatic pulse(input logic [14:0] bits);
        @(posedge clk);
        evt <= bits;
        @(posedge clk);
        evt <= 15'h0000;
    endtask : pulse

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        cnt <= 4'hA;
        rdc("group after reset", IDX_GROUP, 16'h1000);
        rdc("supervision view", IDX_SUPERVISION, 16'h400A);
    endtask : t_reset

    task automatic t_comm();
        pulse(15'h2000);
        rdc("group crc", IDX_GROUP, 16'h9000);
        access(1'b1, IDX_GROUP, 16'hFFFF);
        rdc("group after write", IDX_GROUP, 16'h9000);
        access(1'b1, IDX_DIAG, 16'h0004);
        rdc("group crc cleared", IDX_GROUP, 16'h1000);
        pulse(15'h6000);
        access(1'b1, IDX_DIAG, 16'h0002);
        rdc("group crc left", IDX_GROUP, 16'h9000);
        access(1'b1, IDX_DIAG, 16'h0006);
        rdc("group both cleared", IDX_GROUP, 16'h1000);
    endtask : t_comm

    task automatic t_pin();
        pulse(15'h0100);
        rdc("group power good diag", IDX_GROUP, 16'h3000);
        pulse(15'h1000);
        access(1'b1, IDX_PIN_STATUS, 16'h8000);
        rdc("group reset diag left", IDX_GROUP, 16'h3000);
        access(1'b1, IDX_PIN_STATUS, 16'h0100);
        rdc("group pin cleared", IDX_GROUP, 16'h1000);
    endtask : t_pin

    task automatic t_mon();
        int pos[6] = '{15, 14, 13, 12, 5, 4};
        access(1'b1, IDX_MON_STATUS, 16'h4000);
        rdc("group no monitor fault", IDX_GROUP, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            pulse(15'(1 << i));
            rdc("group monitor fault", IDX_GROUP, 16'h1000);
            access(1'b1, IDX_MON_STATUS, 16'(1 << pos[i]));
            rdc("group monitor cleared", IDX_GROUP, 16'h0000);
        end
    endtask : t_mon

    task automatic t_live();
        state <= 5'h16;
        live <= 5'h1F;
        pins <= 2'h3;
        // the state read gives the pin synchroniser its two edges
        rdc("state view", IDX_STATE, 16'h2A16);
        rdc("pin status view", IDX_PIN_STATUS, 16'h2C00);
        rdc("diag view", IDX_DIAG, 16'h0800);
        rdc("unmapped index", 4'hC, 16'h0000);
        access(1'b1, IDX_REACT_AUX, 16'hFFFF);
        check("aux output", aux_cfg, 16'h000F);
        rdc("aux reserved bits", IDX_REACT_AUX, 16'h000F);
        access(1'b1, IDX_SUPERVISION, 16'hFFFF);
        check("supervision output", sup_cfg, 16'hC210);
        rdc("supervision full view", IDX_SUPERVISION, 16'hC21A);
    endtask : t_live

    // a held crc flag must not survive a reset in mid-run
    task automatic t_rerun();
        pulse(15'h2000);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        rdc("group after second reset", IDX_GROUP, 16'h1000);
    endtask : t_rerun

    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_comm();
        t_pin();
        t_mon();
        t_live();
        t_rerun();
        end_of_test();
    end

    // all scenarios take well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        end_of_test();
    end
endmodule : fsr_readback_bench
